// file: logic/dyn_load_pkg.sv
// Purpose: Shared constants and types for the dynamic load sequencer
// Assumes: 50 MHz clk, 32-bit Avalon-MM register word
// Notes:   Setpoints are unsigned milliamp codes, voltages millivolt codes
package dyn_load_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 50000000;
	localparam int CLK_PER_US      = CLK_HZ / 1000000;
	localparam int WIDTH_MIN_NS    = 20000;
	localparam int WIDTH_MIN_CYC   = (WIDTH_MIN_NS * CLK_PER_US + 999) / 1000;
	localparam int WIDTH_MAX_S     = 999;
	localparam int RATE_MIN_MA_US  = 1;
	localparam int RATE_MAX_MA_US  = 2500;

	// ----------------------------------------------------------------
	// Register word offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_CTRL    = 6'h00;
	localparam logic [5:0] OFS_LEVEL_A = 6'h04;
	localparam logic [5:0] OFS_LEVEL_B = 6'h08;
	localparam logic [5:0] OFS_RATES   = 6'h0c;
	localparam logic [5:0] OFS_WIDTH   = 6'h10;
	localparam logic [5:0] OFS_PRESC   = 6'h14;
	localparam logic [5:0] OFS_PROTECT_VOLTAGE_THRESHOLD   = 6'h18;
	localparam logic [5:0] OFS_I_START = 6'h1c;
	localparam logic [5:0] OFS_I_STEP  = 6'h20;
	localparam logic [5:0] OFS_I_END   = 6'h24;
	localparam logic [5:0] OFS_I_MIN   = 6'h28;
	localparam logic [5:0] OFS_I_MAX   = 6'h2c;
	localparam logic [5:0] OFS_DELAY   = 6'h30;
	localparam logic [5:0] OFS_STATUS  = 6'h34;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;   // 2 bits
	localparam int CTRL_SRC_LSB  = 2;   // 2 bits
	localparam int CTRL_IRNG_BIT = 4;
	localparam int CTRL_VRNG_BIT = 5;
	localparam int CTRL_ON_BIT   = 6;
	localparam int CTRL_OVERCURRENT_PROTECTION_TEST_BIT = 7;
	localparam int CTRL_SWTRG    = 8;   // write 1: bus trigger
	localparam int CTRL_MANTRG   = 9;   // write 1: manual trigger softkey
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] PRESC_RESET = 32'h0000_0031;

	typedef enum logic [1:0] {
		MODE_CONT   = 2'h0,
		MODE_PULSE  = 2'h1,
		MODE_TOGGLE = 2'h2
	} dyn_mode_t;

	typedef enum logic [1:0] {
		SRC_MANUAL = 2'h0,
		SRC_EXT    = 2'h1,
		SRC_BUS    = 2'h2
	} trig_src_t;

	// Protection test states, gray along idle-wait-step-done
	typedef enum logic [2:0] {
		OT_IDLE = 3'b000,
		OT_WAIT = 3'b001,
		OT_STEP = 3'b011,
		OT_DONE = 3'b010
	} overcurrent_protection_test_state_t;

	typedef struct packed {
		logic [15:0] setpoint;
		logic        sink_on;
		logic        irange_hi;
		logic        vrange_hi;
	} sink_cmd_t;

	typedef struct packed {
		logic busy;
		logic pass;
		logic fail;
		logic level_b;
	} seq_status_t;

endpackage

// file: logic/dynamic_load_sequencer.sv
// Purpose: Dynamic level sequencer and overcurrent protection test engine
// Assumes: Avalon-MM slave, one wait state on every access
// Notes:
`timescale 1ns/1ns

module dynamic_load_sequencer
	import dyn_load_pkg::*;
#(
	parameter int LVL_W = 16
)
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Avalon-MM slave
	input  wire logic [5:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// Trigger pin and measurement
	input  wire logic                ext_trig,
	input  wire logic [LVL_W-1:0]    meas_voltage,
	input  wire logic [LVL_W-1:0]    meas_current,
	// Sink stage command and sequencer status
	output sink_cmd_t                sink_cmd,
	output seq_status_t              status
);

	initial
	begin
		if (LVL_W != 16)
			$error("LVL_W must be 16");
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg, level_a_reg, level_b_reg, rates_reg, width_reg;
	logic [31:0] presc_reg, protect_voltage_threshold_reg, i_start_reg, i_step_reg, i_end_reg;
	logic [31:0] i_min_reg, i_max_reg, delay_reg;
	logic        ack_reg;
	logic        bus_trg_reg, man_trg_reg;
	logic        pass_reg, fail_reg, level_b_reg_st;
	logic [15:0] set_reg;
	logic        sink_on_reg;
	overcurrent_protection_test_state_t ot_state_reg;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	wire logic acc  = (read | write) & ~ack_reg;
	// Writes land at the edge where waitrequest is sampled low
	wire logic wr_e = write & ack_reg;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ack_reg <= 1'b0;
		else
			ack_reg <= acc;
	end

	always_comb waitrequest = ~ack_reg & (read | write);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_reg    <= CTRL_RESET;
			level_a_reg <= '0;
			level_b_reg <= '0;
			rates_reg   <= 32'h0001_0001;
			width_reg   <= 32'h0000_0001;
			presc_reg   <= PRESC_RESET;
			protect_voltage_threshold_reg   <= '0;
			i_start_reg <= '0;
			i_step_reg  <= '0;
			i_end_reg   <= '0;
			i_min_reg   <= '0;
			i_max_reg   <= '0;
			delay_reg   <= 32'h0000_0001;
		end
		else if (wr_e)
		begin
			case (address)
				OFS_CTRL:    ctrl_reg    <= merge(ctrl_reg, writedata,
				                                 byteenable);
				OFS_LEVEL_A: level_a_reg <= merge(level_a_reg, writedata,
				                                 byteenable);
				OFS_LEVEL_B: level_b_reg <= merge(level_b_reg, writedata,
				                                 byteenable);
				OFS_RATES:   rates_reg   <= merge(rates_reg, writedata,
				                                 byteenable);
				OFS_WIDTH:   width_reg   <= merge(width_reg, writedata,
				                                 byteenable);
				OFS_PRESC:   presc_reg   <= merge(presc_reg, writedata,
				                                 byteenable);
				OFS_PROTECT_VOLTAGE_THRESHOLD:   protect_voltage_threshold_reg   <= merge(protect_voltage_threshold_reg, writedata,
				                                 byteenable);
				OFS_I_START: i_start_reg <= merge(i_start_reg, writedata,
				                                 byteenable);
				OFS_I_STEP:  i_step_reg  <= merge(i_step_reg, writedata,
				                                 byteenable);
				OFS_I_END:   i_end_reg   <= merge(i_end_reg, writedata,
				                                 byteenable);
				OFS_I_MIN:   i_min_reg   <= merge(i_min_reg, writedata,
				                                 byteenable);
				OFS_I_MAX:   i_max_reg   <= merge(i_max_reg, writedata,
				                                 byteenable);
				OFS_DELAY:   delay_reg   <= merge(delay_reg, writedata,
				                                 byteenable);
				default:     ;
			endcase
		end
	end

	// Self-clearing trigger strobes from control writes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bus_trg_reg <= 1'b0;
			man_trg_reg <= 1'b0;
		end
		else
		begin
			bus_trg_reg <= wr_e && address == OFS_CTRL && byteenable[1]
			               && writedata[CTRL_SWTRG];
			man_trg_reg <= wr_e && address == OFS_CTRL && byteenable[1]
			               && writedata[CTRL_MANTRG];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			readdata <= '0;
		else if (acc && read)
		begin
			case (address)
				OFS_CTRL:    readdata <= {24'h0, ctrl_reg[7:0]};
				OFS_LEVEL_A: readdata <= level_a_reg;
				OFS_LEVEL_B: readdata <= level_b_reg;
				OFS_RATES:   readdata <= rates_reg;
				OFS_WIDTH:   readdata <= width_reg;
				OFS_PRESC:   readdata <= presc_reg;
				OFS_PROTECT_VOLTAGE_THRESHOLD:   readdata <= protect_voltage_threshold_reg;
				OFS_I_START: readdata <= i_start_reg;
				OFS_I_STEP:  readdata <= i_step_reg;
				OFS_I_END:   readdata <= i_end_reg;
				OFS_I_MIN:   readdata <= i_min_reg;
				OFS_I_MAX:   readdata <= i_max_reg;
				OFS_DELAY:   readdata <= delay_reg;
				OFS_STATUS:  readdata <= {4'h0, set_reg, 5'h00,
				                 ot_state_reg, pass_reg, fail_reg,
				                 sink_on_reg, level_b_reg_st};
				default:     readdata <= '0;
			endcase
		end
	end

	wire dyn_mode_t m    = dyn_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
	wire trig_src_t src  = trig_src_t'(ctrl_reg[CTRL_SRC_LSB +: 2]);
	wire logic     run   = ctrl_reg[CTRL_ON_BIT];
	wire logic     overcurrent_protection_test  = ctrl_reg[CTRL_OVERCURRENT_PROTECTION_TEST_BIT];

	// ----------------------------------------------------------------
	// Trigger selection
	// ----------------------------------------------------------------
	logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end
		else
		begin
			ext_s1_reg <= ext_trig;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	logic trig;
	always_comb
	begin
		case (src)
			SRC_MANUAL: trig = man_trg_reg;
			SRC_EXT:    trig = ext_s2_reg & ~ext_s3_reg;
			SRC_BUS:    trig = bus_trg_reg;
			default:    trig = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Prescaler tick
	// ----------------------------------------------------------------
	logic [31:0] pre_cnt_reg;
	logic        tick_reg;
	logic        pulse_hold_reg;
	wire  logic  pulse_fire = run && !overcurrent_protection_test && m == MODE_PULSE
	                          && !pulse_hold_reg && trig;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pre_cnt_reg <= '0;
			tick_reg    <= 1'b0;
		end
		else if (pulse_fire)
		begin
			// Restart so a pulse lasts whole prescaled ticks
			pre_cnt_reg <= 32'h1;
			tick_reg    <= (presc_reg == 32'h0);
		end
		else if (pre_cnt_reg >= presc_reg)
		begin
			pre_cnt_reg <= '0;
			tick_reg    <= 1'b1;
		end
		else
		begin
			pre_cnt_reg <= pre_cnt_reg + 32'h1;
			tick_reg    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Dynamic level selection
	// ----------------------------------------------------------------
	logic [31:0] wcnt_reg;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			level_b_reg_st <= 1'b0;
			pulse_hold_reg <= 1'b0;
			wcnt_reg       <= '0;
		end
		else if (!run || overcurrent_protection_test)
		begin
			level_b_reg_st <= 1'b0;
			pulse_hold_reg <= 1'b0;
			wcnt_reg       <= '0;
		end
		else
		begin
			case (m)
				MODE_PULSE:
				begin
					if (pulse_hold_reg)
					begin
						if (tick_reg)
							wcnt_reg <= wcnt_reg + 32'h1;
						if (tick_reg && wcnt_reg + 32'h1 >= width_reg)
						begin
							pulse_hold_reg <= 1'b0;
							level_b_reg_st <= 1'b0;
						end
					end
					else if (trig)
					begin
						pulse_hold_reg <= 1'b1;
						level_b_reg_st <= 1'b1;
						wcnt_reg       <= '0;
					end
					else
						level_b_reg_st <= 1'b0;
				end
				MODE_TOGGLE:
					if (trig)
						level_b_reg_st <= ~level_b_reg_st;
				MODE_CONT:
				begin
					if (tick_reg)
						wcnt_reg <= wcnt_reg + 32'h1;
					if (tick_reg && wcnt_reg + 32'h1 >= width_reg)
					begin
						wcnt_reg       <= '0;
						level_b_reg_st <= ~level_b_reg_st;
					end
				end
				default:
					level_b_reg_st <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Protection test engine
	// ----------------------------------------------------------------
	logic [31:0] dcnt_reg;
	logic [15:0] ot_cur_reg;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ot_state_reg <= OT_IDLE;
			ot_cur_reg   <= '0;
			dcnt_reg     <= '0;
			pass_reg     <= 1'b0;
			fail_reg     <= 1'b0;
		end
		else if (!(run && overcurrent_protection_test))
			ot_state_reg <= OT_IDLE;
		else
		begin
			case (ot_state_reg)
				OT_IDLE:
				begin
					pass_reg <= 1'b0;
					fail_reg <= 1'b0;
					dcnt_reg <= '0;
					if (meas_voltage >= protect_voltage_threshold_reg[15:0])
						ot_state_reg <= OT_WAIT;
				end
				OT_WAIT:
				begin
					if (tick_reg)
						dcnt_reg <= dcnt_reg + 32'h1;
					if (tick_reg && dcnt_reg + 32'h1 >= delay_reg)
					begin
						dcnt_reg     <= '0;
						ot_cur_reg   <= i_start_reg[15:0];
						ot_state_reg <= OT_STEP;
					end
				end
				OT_STEP:
				begin
					if (ot_cur_reg >= i_end_reg[15:0])
					begin
						fail_reg     <= 1'b1;
						ot_state_reg <= OT_DONE;
					end
					else if (meas_voltage < protect_voltage_threshold_reg[15:0])
					begin
						if (meas_current >= i_min_reg[15:0] &&
						    meas_current <= i_max_reg[15:0])
							pass_reg <= 1'b1;
						else
							fail_reg <= 1'b1;
						ot_state_reg <= OT_DONE;
					end
					else
					begin
						if (tick_reg)
							dcnt_reg <= dcnt_reg + 32'h1;
						if (tick_reg && dcnt_reg + 32'h1 >= delay_reg)
						begin
							dcnt_reg   <= '0;
							ot_cur_reg <= ot_cur_reg
							              + i_step_reg[15:0];
						end
					end
				end
				OT_DONE: ;
				default: ot_state_reg <= OT_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Slew-limited setpoint output
	// ----------------------------------------------------------------
	logic [15:0] target;
	logic        want_on;
	always_comb
	begin
		want_on = run;
		if (overcurrent_protection_test)
		begin
			want_on = run && ot_state_reg == OT_STEP;
			target  = ot_cur_reg;
		end
		else
			target = level_b_reg_st ? level_b_reg[15:0]
			                        : level_a_reg[15:0];
		if (!want_on)
			target = '0;
	end

	// Rates are mA per us: one us is CLK_PER_US cycles
	logic [7:0] us_cnt_reg;
	wire  logic us_tick = (us_cnt_reg == 8'(CLK_PER_US - 1));
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			us_cnt_reg <= '0;
		else if (us_tick)
			us_cnt_reg <= '0;
		else
			us_cnt_reg <= us_cnt_reg + 8'h1;
	end

	wire logic [15:0] up_r = rates_reg[15:0];
	wire logic [15:0] dn_r = rates_reg[31:16];
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			set_reg <= '0;
		else if (us_tick)
		begin
			if (target > set_reg)
				set_reg <= (target - set_reg > up_r) ? set_reg + up_r
				                                     : target;
			else if (target < set_reg)
				set_reg <= (set_reg - target > dn_r) ? set_reg - dn_r
				                                     : target;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sink_on_reg <= 1'b0;
			sink_cmd    <= '0;
			status      <= '0;
		end
		else
		begin
			sink_on_reg <= want_on;
			sink_cmd    <= '{set_reg, want_on, ctrl_reg[CTRL_IRNG_BIT],
			                 ctrl_reg[CTRL_VRNG_BIT]};
			status      <= '{ot_state_reg != OT_IDLE &&
			                 ot_state_reg != OT_DONE, pass_reg,
			                 fail_reg, level_b_reg_st};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_pulse_fire;
		run && !overcurrent_protection_test && m == MODE_PULSE && !pulse_hold_reg && trig;
	endsequence

	a_pulse_starts_b: assert property (s_pulse_fire |=> level_b_reg_st)
		else $error("pulse trigger did not select level B");
	a_pulse_ignores_trg: assert property (
		run && !overcurrent_protection_test && m == MODE_PULSE && pulse_hold_reg && trig
		&& !(tick_reg && wcnt_reg + 32'h1 >= width_reg)
		|=> pulse_hold_reg && wcnt_reg == $past(wcnt_reg)
		    + {31'h0, $past(tick_reg)})
		else $error("trigger disturbed active pulse");
	a_pulse_rest_low: assert property (
		run && !overcurrent_protection_test && m == MODE_PULSE && !pulse_hold_reg && !trig
		|=> !level_b_reg_st)
		else $error("pulse mode left low level without trigger");
	a_toggle_flip: assert property (
		run && !overcurrent_protection_test && m == MODE_TOGGLE && trig
		|=> level_b_reg_st != $past(level_b_reg_st))
		else $error("toggle did not alternate");
	a_ext_one_cycle: assert property (
		src == SRC_EXT && trig |=> !trig)
		else $error("external trigger longer than one cycle");
	a_overcurrent_protection_test_end_fail: assert property (
		run && overcurrent_protection_test && ot_state_reg == OT_STEP
		&& ot_cur_reg >= i_end_reg[15:0]
		|=> fail_reg && !pass_reg && ot_state_reg == OT_DONE)
		else $error("final current did not fail test");
	a_overcurrent_protection_test_done_off: assert property (
		overcurrent_protection_test && ot_state_reg == OT_DONE |-> ##1 !sink_on_reg)
		else $error("sink stayed on after test end");
	a_overcurrent_protection_test_start_gate: assert property (
		run && overcurrent_protection_test && ot_state_reg == OT_IDLE
		&& meas_voltage < protect_voltage_threshold_reg[15:0] |=> ot_state_reg == OT_IDLE)
		else $error("test started below threshold");
	a_slew_rise: assert property (
		us_tick && target > set_reg |=> set_reg - $past(set_reg) <= up_r)
		else $error("rise exceeded slew limit");

endmodule

// file: verif/source_model.sv
// Purpose: Behavioural model of the source under test
// Assumes: Drawn current equals the commanded setpoint while sinking
// Notes:   Voltage collapses once the current reaches trip_ma
`timescale 1ns/1ns

module source_model
	import dyn_load_pkg::*;
#(
	parameter logic [15:0] V_HIGH = 16'h2ee0,
	parameter logic [15:0] V_LOW  = 16'h07d0
)
(
	// Load side
	input  wire sink_cmd_t   sink_cmd,
	// Bench control
	input  wire logic [15:0] trip_ma,
	// Measurement
	output logic      [15:0] meas_voltage,
	output logic      [15:0] meas_current
);
	always_comb
	begin
		meas_current = sink_cmd.sink_on ? sink_cmd.setpoint : 16'h0000;
		meas_voltage = (meas_current >= trip_ma) ? V_LOW : V_HIGH;
	end
endmodule

// file: verif/dynamic_load_sequencer_test.sv
// Purpose: Self-checking bench for the dynamic load sequencer
// Assumes: Prescaler 0 gives one tick per clock
// Notes:   Register access through Avalon-MM tasks
`timescale 1ns/1ns

module dynamic_load_sequencer_test;
	import dyn_load_pkg::*;

	logic              clk         = 1'b0;
	logic              nrst        = 1'b0;
	logic [5:0]        address     = 6'h00;
	logic              read        = 1'b0;
	logic              write       = 1'b0;
	logic [31:0]       writedata   = 32'h0;
	logic [31:0]       readdata;
	logic              waitrequest;
	logic              ext_trig    = 1'b0;
	logic [15:0]       trip_ma     = 16'hffff;
	logic [15:0]       meas_voltage;
	logic [15:0]       meas_current;
	sink_cmd_t         sink_cmd;
	seq_status_t       status;
	int                n_mismatch  = 0;
	int                cmp_count   = 0;
	int                k;
	logic [15:0]       sp;

	always #10 clk = ~clk;

	dynamic_load_sequencer i_dynamic_load_sequencer (
		.clk(clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_trig(ext_trig), .meas_voltage(meas_voltage),
		.meas_current(meas_current), .sink_cmd(sink_cmd),
		.status(status)
	);

	source_model i_source_model (
		.sink_cmd(sink_cmd), .trip_ma(trip_ma),
		.meas_voltage(meas_voltage), .meas_current(meas_current)
	);

	// ------------------------------------------------------------
	// Report and compare
	// ------------------------------------------------------------
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic timed_out();
		n_mismatch++;
		$display("FAIL t=%0t wait limit reached", $time);
		final_report();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Bus and wait helpers
	// ------------------------------------------------------------
	task automatic bus(input logic wr_n_rd, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		address   <= a;
		writedata <= d;
		write     <= wr_n_rd;
		read      <= !wr_n_rd;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			timed_out();
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (status.level_b !== v && n < 2000);
		if (n >= 2000)
			timed_out();
	endtask

	task automatic ocp_run(input logic [15:0] trip, input logic [1:0] exp);
		int n;
		trip_ma <= trip;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'hc0);
		// Old verdict flags stand until the test leaves idle
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (status.busy !== 1'b1 && n < 50);
		check(status.busy, 1'b1);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (status.pass !== 1'b1 && status.fail !== 1'b1 && n < 5000);
		if (n >= 5000)
			timed_out();
		repeat (3) @(posedge clk);
		check({status.pass, status.fail}, exp);
		check(sink_cmd.sink_on, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(OFS_CTRL, CTRL_RESET);
		rd_chk(OFS_PRESC, PRESC_RESET);
		rd_chk(OFS_WIDTH, 32'h1);
		rd_chk(6'h38, 32'h0);
		wr(OFS_RATES, 32'h09c4_09c4);
		wr(OFS_LEVEL_A, 32'h64);
		wr(OFS_LEVEL_B, 32'h12c);
		wr(OFS_WIDTH, 32'h96);
		rd_chk(OFS_LEVEL_B, 32'h12c);
		// Pulse mode, bus source, two prescaler settings
		for (int p = 0; p < 2; p++)
		begin
			wr(OFS_PRESC, p);
			wr(OFS_CTRL, 32'h49);
			rd_chk(OFS_CTRL, 32'h49);
			repeat (150) @(posedge clk);
			check(status.level_b, 1'b0);
			check(sink_cmd.setpoint, 16'h64);
			wr(OFS_CTRL, 32'h149);
			wait_lvl(1'b1);
			k = 1;
			fork
				begin
					repeat (20) @(posedge clk);
					wr(OFS_CTRL, 32'h149);
				end
				do
				begin
					@(posedge clk);
					k++;
				end
				while (status.level_b === 1'b1 && k < 1000);
			join
			check(k - 1, 150 * (p + 1));
			repeat (150) @(posedge clk);
			check(sink_cmd.setpoint, 16'h64);
		end
		// Toggle mode, manual source, slow rise
		wr(OFS_PRESC, 32'h0);
		wr(OFS_RATES, 32'h09c4_0032);
		wr(OFS_CTRL, 32'h42);
		repeat (5) @(posedge clk);
		check(status.level_b, 1'b0);
		wr(OFS_CTRL, 32'h242);
		repeat (8) @(posedge clk);
		check(status.level_b, 1'b1);
		repeat (60) @(posedge clk);
		sp = sink_cmd.setpoint;
		check(sp > 16'h64 && sp <= 16'hc8, 1'b1);
		wr(OFS_CTRL, 32'h242);
		repeat (8) @(posedge clk);
		check(status.level_b, 1'b0);
		repeat (100) @(posedge clk);
		check(sink_cmd.setpoint, 16'h64);
		// External source ignores the softkey
		wr(OFS_CTRL, 32'h46);
		wr(OFS_CTRL, 32'h246);
		repeat (8) @(posedge clk);
		check(status.level_b, 1'b0);
		@(posedge clk);
		ext_trig <= 1'b1;
		repeat (4) @(posedge clk);
		ext_trig <= 1'b0;
		repeat (8) @(posedge clk);
		check(status.level_b, 1'b1);
		wr(OFS_CTRL, 32'h76);
		repeat (3) @(posedge clk);
		check({sink_cmd.irange_hi, sink_cmd.vrange_hi}, 2'b11);
		// Continuous mode alternates every width ticks
		wr(OFS_CTRL, 32'h40);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (status.level_b === 1'b1 && k < 1000);
		check(k, 150);
		// Protection test
		wr(OFS_RATES, 32'h09c4_09c4);
		wr(OFS_PROTECT_VOLTAGE_THRESHOLD, 32'h1388);
		wr(OFS_I_START, 32'h64);
		wr(OFS_I_STEP, 32'h64);
		wr(OFS_I_END, 32'h3e8);
		wr(OFS_I_MIN, 32'h12c);
		wr(OFS_I_MAX, 32'h258);
		wr(OFS_DELAY, 32'h64);
		ocp_run(16'h01f4, 2'b10);
		ocp_run(16'h0320, 2'b01);
		ocp_run(16'hea60, 2'b01);
		trip_ma <= 16'h0000;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'hc0);
		repeat (300) @(posedge clk);
		check(sink_cmd.setpoint, 16'h0);
		final_report();
	end
endmodule
